/* File: rtl/retimer_pkg.sv */
/*
 * shared constants and types of the eight-channel retimer path control:
 * register indices, field positions, reset values, mode encodings.
 * assumes one clock domain and 8-bit registers in the low byte lane.
 */
package retimer_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int         NCH            = 8;
	localparam int         NPAIR          = 4;
	localparam logic [3:0] TABLE_LAST_IDX = 4'hf;

	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] REG_DC_GAIN    = 8'h13;
	localparam logic [7:0] REG_TABLE_BASE = 8'h40;
	localparam logic [7:0] REG_TABLE_LAST = 8'h4f;
	localparam logic [7:0] REG_VGA        = 8'h8e;
	localparam logic [7:0] REG_CTRL       = 8'h90;
	localparam logic [7:0] REG_STATUS     = 8'h91;
	localparam logic [7:0] REG_HEO        = 8'h92;
	localparam logic [7:0] REG_VEO        = 8'h93;
	localparam logic [7:0] REG_BOOST      = 8'h94;
	localparam logic [7:0] REG_PSEUDO_RANDOM_PATTERN_ERR   = 8'h95;
	localparam logic [7:0] REG_XPT        = 8'h96;
	localparam logic [7:0] REG_DEV_ADDR   = 8'h97;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int DC_GAIN_BIT      = 5;
	localparam int VGA_BIT          = 0;
	localparam int CTRL_READAPT_BIT = 0;
	localparam int CTRL_CDR_RST_BIT = 1;
	localparam int CTRL_SD_LSB      = 2;
	localparam int CTRL_PSEUDO_RANDOM_PATTERN_BIT    = 4;
	localparam int XPT_SRC_BIT      = 2;

	// ************************************************************
	// encodings
	// ************************************************************
	typedef enum logic [1:0] {
		SD_AUTO      = 2'h0,
		SD_FORCE_OFF = 2'h1,
		SD_FORCE_ON  = 2'h2,
		SD_AUTO_ALT  = 2'h3
	} sd_mode_t;

	typedef enum logic [1:0] {
		XPT_STRAIGHT = 2'h0,
		XPT_MUX      = 2'h1,
		XPT_FANOUT   = 2'h2,
		XPT_CROSS    = 2'h3
	} xpt_mode_t;

	typedef enum logic [2:0] {
		AD_IDLE    = 3'h0,
		AD_APPLY   = 3'h1,
		AD_MEASURE = 3'h2,
		AD_FINAL   = 3'h3,
		AD_FROZEN  = 3'h4
	} adapt_state_t;

	// four stages of two bits, stage one in the low pair
	typedef struct packed {
		logic [1:0] stage4;
		logic [1:0] stage3;
		logic [1:0] stage2;
		logic [1:0] stage1;
	} boost_t;

	// per-channel software registers
	typedef struct packed {
		logic [15:0][7:0] table_e;
		logic             dc_gain;
		logic             vga_en;
		logic             readapt;
		logic             cdr_rst;
		sd_mode_t         sd_mode;
		logic             pseudo_random_pattern_en;
		xpt_mode_t        xpt_mode;
		logic             xpt_src;
		logic             err_clr;
	} chan_regs_t;

	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic [15:0][7:0] BOOST_TABLE_RST = {
		8'hea, 8'hfa, 8'hfe, 8'hff, 8'hbf, 8'haf, 8'hab, 8'haa,
		8'h6a, 8'h5a, 8'h56, 8'h55, 8'h15, 8'h05, 8'h01, 8'h00};
	localparam chan_regs_t CH_RST = '{
		table_e:  BOOST_TABLE_RST,
		vga_en:   1'b1,
		sd_mode:  SD_AUTO,
		xpt_mode: XPT_STRAIGHT,
		default:  '0};
	localparam logic [6:0] PSEUDO_RANDOM_PATTERN_SEED         = 7'h7f;
	localparam logic [1:0] STRAP_CAPTURE_CNT = 2'h2;

endpackage : retimer_pkg

/* File: rtl/chan_if.sv */
/*
 * carrier between the top and one channel's adaptation engine.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface chan_if;
	import retimer_pkg::*;

	logic [3:0] idx;
	logic [7:0] entry;
	logic       readapt;
	logic       restart;
	logic       locked;
	logic       eye_valid;
	logic [7:0] horizontal_eye_width;
	logic [7:0] vertical_eye_height;
	boost_t     boost;
	logic       frozen;
	logic       pseudo_random_pattern_en;
	logic       rx_bit;
	logic       pseudo_random_pattern_bit;
	logic       err_clr;
	logic [7:0] err_cnt;

	modport ctl (
		input  idx, boost, frozen, pseudo_random_pattern_bit, err_cnt,
		output entry, readapt, restart, locked, eye_valid, horizontal_eye_width, vertical_eye_height, pseudo_random_pattern_en, rx_bit, err_clr
	);
	modport chan (
		output idx, boost, frozen, pseudo_random_pattern_bit, err_cnt,
		input  entry, readapt, restart, locked, eye_valid, horizontal_eye_width, vertical_eye_height, pseudo_random_pattern_en, rx_bit, err_clr
	);
endinterface : chan_if

/* File: rtl/pair_switch.sv */
/*
 * one 2x2 routing switch between channels a and b.
 * purely combinational; the caller registers the outputs.
 */
`timescale 1ns/1ns
module pair_switch
	import retimer_pkg::*;
(
	// inputs of the pair
	input  wire logic      in_a,
	input  wire logic      in_b,
	// routing choice
	input  wire xpt_mode_t mode,
	input  wire logic      src,
	// outputs of the pair
	output logic           out_a,
	output logic           out_b
);
	// ************************************************************
	// routing
	// ************************************************************

	// mux leaves output b idle low so a dead lane is visible
	always_comb begin
		case (mode)
			XPT_STRAIGHT: begin
				out_a = in_a;
				out_b = in_b;
			end
			XPT_MUX: begin
				out_a = src ? in_b : in_a;
				out_b = 1'b0;
			end
			XPT_FANOUT: begin
				out_a = src ? in_b : in_a;
				out_b = src ? in_b : in_a;
			end
			XPT_CROSS: begin
				out_a = in_b;
				out_b = in_a;
			end
			default: begin
				out_a = in_a;
				out_b = in_b;
			end
		endcase
	end
endmodule : pair_switch

/* File: rtl/chan_adapt.sv */
/*
 * one channel: equalizer boost sweep over the boost table, freeze at the
 * end of the sweep, and the pseudo_random_pattern generator and checker.
 * assumes locked is already synchronised and eye values share the clock.
 */
`timescale 1ns/1ns
module chan_adapt
	import retimer_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// link to the top
	chan_if.chan      ifc
);
	typedef struct packed {
		adapt_state_t st;
		logic [3:0]   idx;
		logic [3:0]   best_idx;
		logic [8:0]   best_score;
		boost_t       boost;
		logic [6:0]   lfsr;
		logic [6:0]   chk;
		logic [7:0]   err_cnt;
	} ch_state_t;

	ch_state_t  r;
	ch_state_t  d;
	logic [8:0] score_w;
	logic       req_w;
	logic       new_best;
	logic       err;

	assign score_w      = {1'b0, ifc.horizontal_eye_width} + {1'b0, ifc.vertical_eye_height};
	assign req_w        = ifc.readapt | ifc.restart;
	assign ifc.idx      = r.idx;
	assign ifc.boost    = r.boost;
	assign ifc.frozen   = (r.st == AD_FROZEN);
	assign ifc.pseudo_random_pattern_bit = r.lfsr[6];
	assign ifc.err_cnt  = r.err_cnt;

	// ************************************************************
	// next state
	// ************************************************************

	// a restart request wins over every state so a sweep never finishes stale
	always_comb begin
		d        = r;
		new_best = (r.idx == 4'h0) || (score_w > r.best_score);
		err      = ifc.pseudo_random_pattern_en && (ifc.rx_bit != (r.chk[6] ^ r.chk[5]));
		if (req_w) begin
			d.st  = AD_APPLY;
			d.idx = 4'h0;
		end else begin
			case (r.st)
				AD_IDLE: begin
					d.st  = AD_APPLY;
					d.idx = 4'h0;
				end
				AD_APPLY: begin
					d.boost = boost_t'(ifc.entry);
					d.st    = AD_MEASURE;
				end
				AD_MEASURE: begin
					if (ifc.eye_valid) begin
						if (new_best) begin
							d.best_score = score_w;
							d.best_idx   = r.idx;
						end
						if (r.idx == TABLE_LAST_IDX) begin
							d.idx = new_best ? r.idx : r.best_idx;
							d.st  = AD_FINAL;
						end else begin
							d.idx = r.idx + 4'h1;
							d.st  = AD_APPLY;
						end
					end
				end
				AD_FINAL: begin
					d.boost = boost_t'(ifc.entry);
					d.st    = AD_FROZEN;
				end
				AD_FROZEN: begin
					// losing lock means the loop went back to acquisition
					if (!ifc.locked) begin
						d.st  = AD_APPLY;
						d.idx = 4'h0;
					end
				end
				default: d.st = AD_IDLE;
			endcase
		end
		// x^7 + x^6 + 1 generator and self-synchronising checker
		d.lfsr = {r.lfsr[5:0], r.lfsr[6] ^ r.lfsr[5]};
		d.chk  = {r.chk[5:0], ifc.rx_bit};
		// an error in the clearing cycle still counts
		if (ifc.err_clr) begin
			d.err_cnt = {7'h0, err};
		end else if (err && (r.err_cnt != 8'hff)) begin
			d.err_cnt = r.err_cnt + 8'h01;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r <= '{st: AD_IDLE, lfsr: PSEUDO_RANDOM_PATTERN_SEED, default: '0};
		end else begin
			r <= d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_restart_req;
		ifc.readapt || ifc.restart;
	endsequence
	sequence s_settle;
		(r.st == AD_FINAL) ##1 (r.st == AD_FROZEN || r.st == AD_APPLY);
	endsequence

	a_restart_sweep: assert property (s_restart_req |=> (r.st == AD_APPLY && r.idx == 4'h0))
		else $error("restart did not begin a new sweep");
	a_frozen_hold: assert property (
		(r.st == AD_FROZEN && !req_w && ifc.locked) |=> ($stable(r.boost) && r.st == AD_FROZEN))
		else $error("boost moved while frozen");
	a_lock_loss: assert property ((r.st == AD_FROZEN && !req_w && !ifc.locked) |=> r.st == AD_APPLY)
		else $error("lock loss did not restart adaptation");
	a_first_score: assert property (
		(r.st == AD_MEASURE && ifc.eye_valid && !req_w && r.idx == 4'h0)
		|=> r.best_score == $past(score_w))
		else $error("first merit score not stored");
	a_sweep_end: assert property (
		(r.st == AD_MEASURE && ifc.eye_valid && !req_w && r.idx == TABLE_LAST_IDX) |=> s_settle)
		else $error("sweep did not settle after sixteen entries");
	a_final_boost: assert property ((r.st == AD_FINAL && !req_w) |=> r.boost == $past(ifc.entry))
		else $error("best table entry not applied");
	a_pseudo_random_pattern_clear: assert property (ifc.err_clr |=> r.err_cnt <= 8'h01)
		else $error("error count not cleared");
endmodule : chan_adapt

/* File: rtl/retimer_path_ctrl.sv */
/*
 * per-channel and per-pair control of an eight-channel retimer: signal
 * detect gating, pair routing, equalizer adaptation, gain bits, eye
 * readback, pattern diagnostics, behind an Avalon-MM slave with waitrequest.
 * assumes the serial management master sits outside and loads words over
 * the config port; pins arrive asynchronous, eye values share the clock.
 */
`timescale 1ns/1ns
module retimer_path_ctrl
	import retimer_pkg::*;
(
	// clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        NRST_I,
	// register bus
	input  wire logic [12:0] AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// configuration loader
	input  wire logic        CFG_WR_I,
	input  wire logic [10:0] CFG_ADDR_I,
	input  wire logic [7:0]  CFG_DATA_I,
	// address strap
	input  wire logic [3:0]  DEV_ADDR_STRAP_I,
	// channel inputs
	input  wire logic [7:0]  RX_DATA_I,
	input  wire logic [7:0]  SIG_DET_I,
	input  wire logic [7:0]  CDR_LOCK_I,
	input  wire logic [7:0]  EYE_VALID_I,
	input  wire logic [63:0] EYE_HEO_I,
	input  wire logic [63:0] EYE_VEO_I,
	// channel outputs
	output logic      [7:0]  TX_DATA_O,
	output logic      [7:0]  PATH_EN_O,
	output logic      [63:0] EQ_BOOST_O,
	output logic      [7:0]  VGA_EN_O,
	output logic      [7:0]  DC_GAIN_O,
	output logic      [7:0]  CDR_RST_O
);
	typedef struct packed {
		chan_regs_t [NCH-1:0]      ch;
		logic [7:0]                rx_meta;
		logic [7:0]                rx_s;
		logic [7:0]                sd_meta;
		logic [7:0]                sd_s;
		logic [7:0]                lk_meta;
		logic [7:0]                lk_s;
		logic [7:0]                tx;
		logic [7:0]                path;
		logic [NCH-1:0][7:0]       horizontal_eye_width;
		logic [NCH-1:0][7:0]       vertical_eye_height;
		logic                      waitreq;
		logic [31:0]               rdata;
		logic [3:0]                strap_meta;
		logic [3:0]                strap_s;
		logic [3:0]                dev_addr;
		logic [1:0]                strap_cnt;
	} state_t;

	localparam state_t ST_RST = '{ch: {NCH{CH_RST}}, waitreq: 1'b1, default: '0};

	state_t              r;
	state_t              d;
	boost_t [NCH-1:0]    boost_w;
	logic [NCH-1:0][3:0] idx_w;
	logic [NCH-1:0][7:0] err_w;
	logic [NCH-1:0]      frozen_w;
	logic [NCH-1:0]      pseudo_random_pattern_w;
	logic [NCH-1:0]      rx_g;
	logic [NCH-1:0]      xy_w;
	logic                req;
	logic                bus_wr;
	logic [2:0]          rc;
	logic [7:0]          ra;
	logic [7:0]          rb;
	logic                mapped;

	// ************************************************************
	// address decode and register write
	// ************************************************************
	function automatic logic [2:0] word_chan(input logic [10:0] w);
		word_chan = w[10:8];
	endfunction : word_chan

	function automatic logic [7:0] word_reg(input logic [10:0] w);
		word_reg = w[7:0];
	endfunction : word_reg

	function automatic chan_regs_t reg_write(input chan_regs_t c, input logic [7:0] a,
			input logic [7:0] wd);
		chan_regs_t n;
		n = c;
		if (a >= REG_TABLE_BASE && a <= REG_TABLE_LAST) begin
			n.table_e[a[3:0]] = wd;
		end else begin
			case (a)
				REG_DC_GAIN: n.dc_gain = wd[DC_GAIN_BIT];
				REG_VGA:     n.vga_en  = wd[VGA_BIT];
				REG_CTRL: begin
					n.readapt = wd[CTRL_READAPT_BIT];
					n.cdr_rst = wd[CTRL_CDR_RST_BIT];
					n.sd_mode = sd_mode_t'(wd[CTRL_SD_LSB +: 2]);
					n.pseudo_random_pattern_en = wd[CTRL_PSEUDO_RANDOM_PATTERN_BIT];
				end
				REG_PSEUDO_RANDOM_PATTERN_ERR: n.err_clr = 1'b1;
				REG_XPT: begin
					n.xpt_mode = xpt_mode_t'(wd[1:0]);
					n.xpt_src  = wd[XPT_SRC_BIT];
				end
				default: n = c;
			endcase
		end
		reg_write = n;
	endfunction : reg_write

	assign req    = AVS_READ_I | AVS_WRITE_I;
	assign bus_wr = AVS_WRITE_I && !r.waitreq && AVS_BYTEENABLE_I[0];

	// ************************************************************
	// channels and pair switches
	// ************************************************************
	chan_if cif [NCH] ();

	// one independent engine per channel, nothing shared between them
	for (genvar g = 0; g < NCH; g++) begin : g_chan
		assign cif[g].entry     = r.ch[g].table_e[cif[g].idx];
		assign cif[g].readapt   = r.ch[g].readapt;
		assign cif[g].restart   = r.ch[g].cdr_rst;
		assign cif[g].locked    = r.lk_s[g];
		assign cif[g].eye_valid = EYE_VALID_I[g];
		assign cif[g].horizontal_eye_width       = EYE_HEO_I[g*8 +: 8];
		assign cif[g].vertical_eye_height       = EYE_VEO_I[g*8 +: 8];
		assign cif[g].pseudo_random_pattern_en   = r.ch[g].pseudo_random_pattern_en;
		assign cif[g].rx_bit    = r.rx_s[g];
		assign cif[g].err_clr   = r.ch[g].err_clr;
		assign boost_w[g]       = cif[g].boost;
		assign idx_w[g]         = cif[g].idx;
		assign err_w[g]         = cif[g].err_cnt;
		assign frozen_w[g]      = cif[g].frozen;
		assign pseudo_random_pattern_w[g]        = cif[g].pseudo_random_pattern_bit;
		assign rx_g[g]          = r.rx_s[g] & r.path[g];
		assign EQ_BOOST_O[g*8 +: 8] = cif[g].boost;
		assign VGA_EN_O[g]      = r.ch[g].vga_en;
		assign DC_GAIN_O[g]     = r.ch[g].dc_gain;
		assign CDR_RST_O[g]     = r.ch[g].cdr_rst;

		chan_adapt u_chan (
			.clk   (CLOCK_I),
			.rst_n (NRST_I),
			.ifc   (cif[g])
		);
	end

	// the even channel of each pair owns the pair's routing register
	for (genvar p = 0; p < NPAIR; p++) begin : g_pair
		pair_switch u_sw (
			.in_a  (rx_g[2*p]),
			.in_b  (rx_g[2*p+1]),
			.mode  (r.ch[2*p].xpt_mode),
			.src   (r.ch[2*p].xpt_src),
			.out_a (xy_w[2*p]),
			.out_b (xy_w[2*p+1])
		);
	end

	assign TX_DATA_O         = r.tx;
	assign PATH_EN_O         = r.path;
	assign AVS_READDATA_O    = r.rdata;
	assign AVS_WAITREQUEST_O = r.waitreq;

	// ************************************************************
	// next state
	// ************************************************************

	// readback byte; unmapped indices read zero
	always_comb begin
		rc     = word_chan(AVS_ADDRESS_I[12:2]);
		ra     = word_reg(AVS_ADDRESS_I[12:2]);
		rb     = 8'h00;
		mapped = 1'b1;
		if (ra >= REG_TABLE_BASE && ra <= REG_TABLE_LAST) begin
			rb = r.ch[rc].table_e[ra[3:0]];
		end else begin
			case (ra)
				REG_DC_GAIN:  rb = 8'(r.ch[rc].dc_gain) << DC_GAIN_BIT;
				REG_VGA:      rb = 8'(r.ch[rc].vga_en) << VGA_BIT;
				REG_CTRL:     rb = {3'h0, r.ch[rc].pseudo_random_pattern_en, r.ch[rc].sd_mode,
				                    r.ch[rc].cdr_rst, 1'b0};
				REG_STATUS:   rb = {3'h0, idx_w[rc] == 4'h0, r.path[rc], frozen_w[rc],
				                    r.sd_s[rc], r.lk_s[rc]};
				REG_HEO:      rb = r.horizontal_eye_width[rc];
				REG_VEO:      rb = r.vertical_eye_height[rc];
				REG_BOOST:    rb = boost_w[rc];
				REG_PSEUDO_RANDOM_PATTERN_ERR: rb = err_w[rc];
				REG_XPT:      rb = {5'h0, r.ch[rc].xpt_src, r.ch[rc].xpt_mode};
				REG_DEV_ADDR: rb = {4'h0, r.dev_addr};
				default:      mapped = 1'b0;
			endcase
		end
	end

	// data, detect, lock and strap pins pass two flops before any logic looks at them
	always_comb begin
		d            = r;
		d.rx_meta    = RX_DATA_I;
		d.rx_s       = r.rx_meta;
		d.sd_meta    = SIG_DET_I;
		d.sd_s       = r.sd_meta;
		d.lk_meta    = CDR_LOCK_I;
		d.lk_s       = r.lk_meta;
		d.strap_meta = DEV_ADDR_STRAP_I;
		d.strap_s    = r.strap_meta;
		// strap is caught once both sync stages hold post-reset samples
		if (r.strap_cnt != 2'h3) begin
			d.strap_cnt = r.strap_cnt + 2'h1;
		end
		if (r.strap_cnt == STRAP_CAPTURE_CNT) begin
			d.dev_addr = r.strap_s;
		end
		for (int c = 0; c < NCH; c++) begin
			d.ch[c].readapt = 1'b0;
			d.ch[c].err_clr = 1'b0;
			// eye monitor taps off the slicer, so reading never disturbs data
			if (EYE_VALID_I[c]) begin
				d.horizontal_eye_width[c] = EYE_HEO_I[c*8 +: 8];
				d.vertical_eye_height[c] = EYE_VEO_I[c*8 +: 8];
			end
			case (r.ch[c].sd_mode)
				SD_FORCE_OFF: d.path[c] = 1'b0;
				SD_FORCE_ON:  d.path[c] = 1'b1;
				default:      d.path[c] = r.sd_s[c];
			endcase
			d.tx[c] = r.ch[c].pseudo_random_pattern_en ? pseudo_random_pattern_w[c] : xy_w[c];
		end
		// loader first so a bus write to the same register wins
		if (CFG_WR_I) begin
			d.ch[word_chan(CFG_ADDR_I)] = reg_write(d.ch[word_chan(CFG_ADDR_I)],
				word_reg(CFG_ADDR_I), CFG_DATA_I);
		end
		if (bus_wr) begin
			d.ch[rc] = reg_write(d.ch[rc], ra, AVS_WRITEDATA_I[7:0]);
		end
		// one wait cycle: data is latched on the first edge, served on the next
		if (req && r.waitreq) begin
			d.waitreq = 1'b0;
			d.rdata   = (AVS_READ_I && mapped) ? {24'h0, rb} : 32'h0;
		end else begin
			d.waitreq = 1'b1;
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			r <= ST_RST;
		end else begin
			r <= d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking

	a_bus_wait: assert property (disable iff (!NRST_I)
		(req && r.waitreq) |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
		else $error("waitrequest did not drop for exactly one cycle");
	a_force_off: assert property (disable iff (!NRST_I)
		(r.ch[2].sd_mode == SD_FORCE_OFF) |=> !PATH_EN_O[2])
		else $error("forced-off path still enabled");
	a_auto_path: assert property (disable iff (!NRST_I)
		(r.ch[0].sd_mode == SD_AUTO && r.sd_s[0]) |=> PATH_EN_O[0])
		else $error("detected signal did not power the path");
	a_vga_reset: assert property (!NRST_I |=> VGA_EN_O == 8'hff)
		else $error("gain stage not enabled after reset");
	a_xpt_reset: assert property (!NRST_I |=> r.ch[6].xpt_mode == XPT_STRAIGHT)
		else $error("pair switch not straight after reset");
	a_dc_gain: assert property (disable iff (!NRST_I)
		(bus_wr && rc == 3'h0 && ra == REG_DC_GAIN) |=> DC_GAIN_O[0] == $past(AVS_WRITEDATA_I[5]))
		else $error("dc gain bit not written");
endmodule : retimer_path_ctrl

/* File: sim/link_partner.sv */
/* far-side model: signal detect, lock and eye values per channel, with one eye valid shared by all channels.
   assumes eye opening follows the applied boost code. */
`timescale 1ns/1ns
module link_partner (
	// clock and stimulus
	input  wire logic        clk_i,
	input  wire logic [7:0]  sd_mask_i,
	input  wire logic [7:0]  lk_mask_i,
	input  wire logic [63:0] boost_i,
	// towards the retimer
	output logic      [7:0]  sig_det_o,
	output logic      [7:0]  lock_o,
	output logic      [7:0]  eye_valid_o,
	output logic      [63:0] heo_o,
	output logic      [63:0] veo_o
);
	logic [63:0] prev_q = '0;
	logic [1:0]  cnt_q  = 2'h0;
	// energy per channel; lock held so the sweep can freeze
	assign sig_det_o = sd_mask_i;
	assign lock_o    = lk_mask_i;
	// combinational so a boost changing at this edge is never reported stale
	assign eye_valid_o = {8{boost_i === prev_q && cnt_q == 2'h3}};
	assign heo_o       = boost_i;
	assign veo_o       = boost_i;
	// count steady cycles of the applied boost
	always @(posedge clk_i) begin
		prev_q <= boost_i;
		cnt_q  <= (boost_i !== prev_q) ? 2'h0 : cnt_q + 2'h1;
	end
endmodule : link_partner

/* File: sim/tb_retimer_path_ctrl.sv */
/* self-checking bench for the retimer path control.
   assumes one wait state per bus access and the link partner model. */
`timescale 1ns/1ns
module tb_retimer_path_ctrl;
	import retimer_pkg::*;
	logic        clk = 0, nrst = 0, rd_en = 0, wr_en = 0, cfg_wr = 0, wait_o;
	logic [12:0] addr = '0;
	logic [31:0] wdata = '0, rdata, rv;
	logic [10:0] cfg_addr = '0;
	logic [7:0]  cfg_data = '0, rx = '0, sd = 8'hff, tx, path, vga, dcg, cdr_rst;
	logic [7:0]  lock, eye_v, sdet;
	logic [7:0]  lk = 8'hff, lp = '0;
	logic [3:0]  strap = '0;
	logic [63:0] boost, horizontal_eye_width, vertical_eye_height;
	int          n_mismatch = 0, check_count = 0;
	// 250 MHz clock
	always #2 clk = ~clk;
	retimer_path_ctrl u_retimer_path_ctrl (.CLOCK_I(clk), .NRST_I(nrst),
		.AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
		.AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wait_o), .CFG_WR_I(cfg_wr), .CFG_ADDR_I(cfg_addr),
		.CFG_DATA_I(cfg_data), .DEV_ADDR_STRAP_I(strap), .RX_DATA_I((rx & ~lp) | (tx & lp)),
		.SIG_DET_I(sdet), .CDR_LOCK_I(lock), .EYE_VALID_I(eye_v), .EYE_HEO_I(horizontal_eye_width),
		.EYE_VEO_I(vertical_eye_height), .TX_DATA_O(tx), .PATH_EN_O(path), .EQ_BOOST_O(boost),
		.VGA_EN_O(vga), .DC_GAIN_O(dcg), .CDR_RST_O(cdr_rst));
	link_partner u_link_partner (.clk_i(clk), .sd_mask_i(sd), .lk_mask_i(lk), .boost_i(boost),
		.sig_det_o(sdet), .lock_o(lock), .eye_valid_o(eye_v), .heo_o(horizontal_eye_width), .veo_o(vertical_eye_height));

	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// request stands until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [2:0] ch, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge clk);
		addr  <= {ch, idx, 2'h0};
		wr_en <= wr;
		rd_en <= !wr;
		wdata <= {24'h0, wd};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wait_o !== 1'b0 && n < 50);
		if (n >= 50)
			chk(1'b1, 1'b0);
		rv = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
	endtask : bus

	task rd(input logic [2:0] ch, input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, ch, idx, 8'h00);
		chk(rv, {24'h0, exp});
	endtask : rd

	// expected outputs: gate on input side, then route pair 0
	function logic [7:0] xp(input logic [2:0] m, input logic [7:0] r, input logic [7:0] en);
		logic [7:0] g;
		logic       s;
		g  = r & en;
		s  = m[2] ? g[1] : g[0];
		xp = g;
		case (m[1:0])
			2'h1: xp[1:0] = {1'b0, s};
			2'h2: xp[1:0] = {s, s};
			2'h3: xp[1:0] = {g[0], g[1]};
			default: ;
		endcase
	endfunction : xp

	// main sequence
	initial begin
		strap = 4'($urandom(82740));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rd(0, REG_VGA, 8'h01);
		rd(7, 8'h4c, 8'hff);
		rd(3, 8'h01, 8'h00);
		rd(2, REG_DEV_ADDR, {4'h0, strap});
		for (int i = 0; i < 8; i++) begin
			if (i > 0)
				bus(1'b1, 3'h0, REG_XPT, 8'(i));
			@(posedge clk);
			rx <= 8'($urandom);
			repeat (6) @(posedge clk);
			@(negedge clk);
			chk(tx, xp(3'(i), rx, 8'hff));
		end
		bus(1'b1, 3'h2, REG_CTRL, 8'h04);
		@(posedge clk);
		sd <= 8'hf7;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk(path, 8'hf3);
		chk(tx, xp(3'h7, rx, 8'hf3));
		bus(1'b1, 3'h1, 8'h4c, 8'h10);
		bus(1'b1, 3'h1, REG_CTRL, 8'h01);
		repeat (300) @(posedge clk);
		chk(boost[15:0], 16'hfeff);
		bus(1'b1, 3'h6, REG_CTRL, 8'h02);
		repeat (4) @(posedge clk);
		chk(cdr_rst, 8'h40);
		rd(6, REG_STATUS, 8'h1b);
		bus(1'b1, 3'h6, REG_CTRL, 8'h00);
		lk <= 8'hdf;
		repeat (20) @(posedge clk);
		lk <= 8'hff;
		repeat (300) @(posedge clk);
		chk(boost[55:40], 16'hffff);
		lp <= 8'h08;
		bus(1'b1, 3'h3, REG_CTRL, 8'h18);
		repeat (20) @(posedge clk);
		chk(path, 8'hfb);
		bus(1'b1, 3'h3, REG_PSEUDO_RANDOM_PATTERN_ERR, 8'h00);
		repeat (30) @(posedge clk);
		rd(3, REG_PSEUDO_RANDOM_PATTERN_ERR, 8'h00);
		lp <= 8'h00;
		rx <= 8'h08;
		repeat (300) @(posedge clk);
		rd(3, REG_PSEUDO_RANDOM_PATTERN_ERR, 8'hff);
		bus(1'b1, 3'h0, REG_DC_GAIN, 8'h20);
		bus(1'b1, 3'h4, REG_VGA, 8'h00);
		@(posedge clk);
		cfg_wr   <= 1'b1;
		cfg_addr <= {3'h5, REG_DC_GAIN};
		cfg_data <= 8'h20;
		@(posedge clk);
		cfg_wr <= 1'b0;
		repeat (3) @(posedge clk);
		chk({vga, dcg}, 16'hef21);
		rd(1, 8'h4c, 8'h10);
		rd(0, REG_HEO, 8'hff);
		rd(0, REG_VEO, 8'hff);
		rd(1, REG_BOOST, 8'hfe);
		print_verdict;
	end

	// watchdog well past the expected run length
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		print_verdict;
	end
endmodule : tb_retimer_path_ctrl
